// >>> ssw_params.svh
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH
// Behaviour
// - Reset held while supply low, plus timeout
// - Static toggle beyond timeout asserts reset
// - Active-high reset mirrors active-low reset
// - Watchdog timeout issues configured reset pulse
// - Post-reset long timeout until first toggle
// - Watchdog restarts at every reset pulse end
// - Static toggle repeats pulses every long timeout
// - Disabled watchdog gives no resets or expiry
// - Expired output low until next toggle edge
// - Supply low forces expired output high
// - External clock: 1024/4096 watchdog, 512/2048 pulse
// - Internal mode: timebase input picks 100ms/1.6s
// - Internal mode: 1.6s timeout right after reset
// - Short timeout only after first toggle
// - Internal timebase nominal 6.55 kHz
// - Reduced variant: fixed 1.6s, 50/200ms pulse
// - Chip enable passes through when supply valid and backup inactive
// - Supply low forces chip enable high
// - Battery backup forces chip enable high
// - Power warning low when sense below reference
// - Backup disables comparator, fixes warning level
// - Supply-low output follows supply with no extra delay beyond sync and output register

// ****************************************************************
// Clock and timebase
// ****************************************************************
`define SSW_CLK_HZ          100000000
`define SSW_TB_HZ           6550
`define SSW_TB_DIV          (`SSW_CLK_HZ / `SSW_TB_HZ)
`define SSW_MS_TO_TICKS(ms) (((ms) * `SSW_TB_HZ) / 1000)

// ****************************************************************
// Timeouts and pulse lengths
// ****************************************************************
`define SSW_WD_LONG_MS      1600
`define SSW_WD_SHORT_MS     100
`define SSW_PULSE_MS        50
`define SSW_PULSE_LONG_MS   200
`define SSW_EXT_WD_NORM     1024
`define SSW_EXT_WD_POST     4096
`define SSW_EXT_PULSE       512
`define SSW_EXT_PULSE_LONG  2048

// ****************************************************************
// Register map
// ****************************************************************
`define SSW_REG_CTRL        8'h00
`define SSW_REG_STATUS      8'h04
`define SSW_REG_COUNT       8'h08
`define SSW_CTRL_LONG_BIT   0
`define SSW_CTRL_REDUCED_BIT 1
`define SSW_CTRL_RESET      2'h0
`endif

// >>> ssw_pkg.sv
package ssw_pkg;
    // Pin group, one bit each, all asynchronous to hclk
    typedef struct packed {
        logic supply_low;
        logic backup_active;
        logic power_warn_sense_low;
        logic watchdog_toggle_in;
        logic watchdog_enable;
        logic timebase_source_select;
        logic timebase_input;
        logic chip_enable_in_n;
    } ssw_pins_type;

    typedef struct packed {
        logic reset_n;
        logic reset;
        logic supply_low_n;
        logic watchdog_expired_n;
        logic power_warn_n;
        logic chip_enable_out_n;
    } ssw_outs_type;

    typedef struct packed {
        logic reduced_pins;
        logic long_reset;
    } ssw_ctrl_type;

    // Gray along supply -> pulse -> run
    typedef enum logic [1:0] {
        ST_SUPPLY = 2'b00,
        ST_PULSE  = 2'b01,
        ST_RUN    = 2'b11
    } ssw_state_type;
endpackage

// >>> ssw_top.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "ssw_params.svh"
module ssw_top #(
    parameter int unsigned TB_DIV = `SSW_TB_DIV
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire ssw_pkg::ssw_pins_type pins,
    output ssw_pkg::ssw_outs_type     outs
);
    import ssw_pkg::*;

    // ****************************************************************
    // Timing constants in timebase ticks
    // ****************************************************************
    localparam logic [15:0] T_WD_LONG    = 16'(`SSW_MS_TO_TICKS(`SSW_WD_LONG_MS));
    localparam logic [15:0] T_WD_SHORT   = 16'(`SSW_MS_TO_TICKS(`SSW_WD_SHORT_MS));
    localparam logic [15:0] T_PULSE      = 16'(`SSW_MS_TO_TICKS(`SSW_PULSE_MS));
    localparam logic [15:0] T_PULSE_LONG = 16'(`SSW_MS_TO_TICKS(`SSW_PULSE_LONG_MS));
    localparam logic [15:0] T_EXT_NORM   = 16'(`SSW_EXT_WD_NORM);
    localparam logic [15:0] T_EXT_POST   = 16'(`SSW_EXT_WD_POST);
    localparam logic [15:0] T_EXT_PULSE  = 16'(`SSW_EXT_PULSE);
    localparam logic [15:0] T_EXT_PLONG  = 16'(`SSW_EXT_PULSE_LONG);
    localparam logic [15:0] DIV_LAST     = 16'(TB_DIV - 1);

    function automatic logic [15:0] wd_limit(input logic post, input logic int_mode,
                                             input logic long_norm);
        if (int_mode)
            wd_limit = (post || long_norm) ? T_WD_LONG : T_WD_SHORT;
        else
            wd_limit = post ? T_EXT_POST : T_EXT_NORM;
    endfunction

    function automatic logic [15:0] pulse_len(input logic int_mode, input logic long_rst);
        if (int_mode)
            pulse_len = long_rst ? T_PULSE_LONG : T_PULSE;
        else
            pulse_len = long_rst ? T_EXT_PLONG : T_EXT_PULSE;
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int NPIN = $bits(ssw_pins_type);
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    ssw_pins_type    ps;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= pins[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign ps = ssw_pins_type'(sync2_q);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    ssw_ctrl_type  ctrl_q;
    ssw_state_type state_q;
    ssw_state_type state_d;
    logic [15:0]   div_q;
    logic [15:0]   cnt_q;
    logic [15:0]   cnt_d;
    logic          post_q;
    logic          post_d;
    logic          expired_n_q;
    logic          expired_n_d;
    logic          tog_prev_q;
    logic          tb_prev_q;
    ssw_outs_type  outs_q;
    ssw_outs_type  outs_d;

    wire int_mode  = ps.backup_active | ctrl_q.reduced_pins | ps.timebase_source_select;
    wire long_norm = ps.backup_active | ctrl_q.reduced_pins | ps.timebase_input;
    wire div_tick  = (div_q == DIV_LAST);
    wire tog_edge  = ps.watchdog_toggle_in ^ tog_prev_q;
    wire ext_tick  = ps.timebase_input & ~tb_prev_q;
    // internal ticks come from the divider
    wire tick      = int_mode ? div_tick : ext_tick;
    wire wd_on     = ps.watchdog_enable;
    wire [15:0] lim_now = wd_limit(post_q, int_mode, long_norm);
    wire [15:0] plen    = pulse_len(int_mode, ctrl_q.long_reset);
    wire supply_bad = ps.supply_low;
    wire wd_timeout = wd_on & tick & (cnt_q == lim_now - 16'h0001);
    wire pulse_done = tick & (cnt_q == plen - 16'h0001);

    // Internal timebase divider and edge history
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q      <= 16'h0000;
            tog_prev_q <= 1'b0;
            tb_prev_q  <= 1'b0;
        end
        else
        begin
            div_q      <= div_tick ? 16'h0000 : div_q + 16'h0001;
            tog_prev_q <= ps.watchdog_toggle_in;
            tb_prev_q  <= ps.timebase_input;
        end
    end

    // Reset sequencer and watchdog; one counter serves both phases
    always_comb
    begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        post_d      = post_q;
        expired_n_d = expired_n_q;
        case (state_q)
            ST_SUPPLY:
            begin
                cnt_d = 16'h0000;
                if (!supply_bad)
                    state_d = ST_PULSE;
            end
            ST_PULSE:
            begin
                if (tick)
                    cnt_d = cnt_q + 16'h0001;
                if (pulse_done)
                begin
                    state_d = ST_RUN;
                    cnt_d   = 16'h0000;
                    post_d  = 1'b1;
                end
            end
            ST_RUN:
            begin
                if (!wd_on)
                    cnt_d = 16'h0000;
                else if (tog_edge)
                begin
                    cnt_d  = 16'h0000;
                    post_d = 1'b0;
                end
                else if (wd_timeout)
                begin
                    state_d     = ST_PULSE;
                    cnt_d       = 16'h0000;
                    expired_n_d = 1'b0;
                end
                else if (tick)
                    cnt_d = cnt_q + 16'h0001;
            end
            default:
            begin
                state_d = ST_SUPPLY;
                cnt_d   = 16'h0000;
            end
        endcase
        if (tog_edge && wd_on)
            expired_n_d = 1'b1;
        // supply low forces expiry high, in backup too
        if (supply_bad || ps.backup_active)
            expired_n_d = 1'b1;
        if (supply_bad)
        begin
            state_d = ST_SUPPLY;
            cnt_d   = 16'h0000;
            post_d  = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q     <= ST_SUPPLY;
            cnt_q       <= 16'h0000;
            post_q      <= 1'b1;
            expired_n_q <= 1'b1;
        end
        else
        begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            post_q      <= post_d;
            expired_n_q <= expired_n_d;
        end
    end

    // ****************************************************************
    // Output stage, all registered
    // ****************************************************************
    wire rst_act = (state_d != ST_RUN);
    wire ce_kill = supply_bad | ps.backup_active;
    always_comb
    begin
        // complementary reset pair from one source
        outs_d.reset_n            = ~rst_act;
        outs_d.reset              = rst_act;
        // supply-low output has no extra delay
        outs_d.supply_low_n       = ~supply_bad;
        outs_d.watchdog_expired_n = expired_n_d;
        // comparator drives warning; backup forces low
        outs_d.power_warn_n       = ~(ps.power_warn_sense_low | ps.backup_active);
        outs_d.chip_enable_out_n  = ps.chip_enable_in_n | ce_kill;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            outs_q <= '{reset_n: 1'b0, reset: 1'b1, supply_low_n: 1'b0,
                        watchdog_expired_n: 1'b1, power_warn_n: 1'b0,
                        chip_enable_out_n: 1'b1};
        else
            outs_q <= outs_d;
    end
    assign outs = outs_q;

    // ****************************************************************
    // AHB-Lite slave, zero wait states
    // ****************************************************************
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    wire        addr_ok   = hsel & hready & htrans[1];
    wire [7:0]  a_off     = haddr[7:0];
    wire        hit_ctrl  = (wr_addr_q == `SSW_REG_CTRL);
    wire [31:0] status_w  = {26'h0, post_q, expired_n_q, ps.backup_active,
                             supply_bad, state_q};
    wire [31:0] rd_mux    = (a_off == `SSW_REG_CTRL)   ? {30'h0, ctrl_q} :
                            (a_off == `SSW_REG_STATUS) ? status_w :
                            (a_off == `SSW_REG_COUNT)  ? {16'h0000, cnt_q} :
                            32'h00000000;

    // Read data latched in address phase so hrdata is a flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata    <= 32'h00000000;
        end
        else
        begin
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok)
                wr_addr_q <= a_off;
            if (addr_ok && !hwrite)
                hrdata <= rd_mux;
        end
    end

    // Control register steers timing mode and pulse length
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_q <= ssw_ctrl_type'(`SSW_CTRL_RESET);
        else if (wr_pend_q && hit_ctrl)
            ctrl_q <= ssw_ctrl_type'(hwdata[1:0]);
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_pulse_end;
        state_q == ST_PULSE && pulse_done && !supply_bad;
    endsequence

    sequence s_run_fresh;
        state_q == ST_RUN && cnt_q == 16'h0000 && post_q;
    endsequence
    property p_supply_reset;
        @(posedge hclk) disable iff (!hresetn)
        supply_bad |=> !outs.reset_n && !outs.supply_low_n;
    endproperty
    a_supply_reset: assert property (p_supply_reset)
        else $error("reset not held during supply low");
    property p_reset_pair;
        @(posedge hclk) disable iff (!hresetn)
        outs.reset == !outs.reset_n;
    endproperty
    a_reset_pair: assert property (p_reset_pair)
        else $error("reset outputs not complementary");
    property p_timeout;
        @(posedge hclk) disable iff (!hresetn)
        state_q == ST_RUN && wd_timeout && !tog_edge && !supply_bad && !ps.backup_active
        |=> state_q == ST_PULSE && !outs.reset_n && !outs.watchdog_expired_n;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("watchdog timeout gave no reset pulse");
    property p_pulse_restart;
        @(posedge hclk) disable iff (!hresetn)
        s_pulse_end |=> s_run_fresh ##0 outs.reset_n;
    endproperty
    a_pulse_restart: assert property (p_pulse_restart)
        else $error("watchdog not restarted at pulse end");
    property p_disabled;
        @(posedge hclk) disable iff (!hresetn)
        !wd_on && state_q == ST_RUN && !supply_bad |=> state_q == ST_RUN;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled watchdog caused reset");
    property p_expired_release;
        @(posedge hclk) disable iff (!hresetn)
        !outs.watchdog_expired_n && tog_edge && wd_on |=> outs.watchdog_expired_n;
    endproperty
    a_expired_release: assert property (p_expired_release)
        else $error("expired output not released by toggle");
    property p_expired_supply;
        @(posedge hclk) disable iff (!hresetn)
        supply_bad || ps.backup_active |=> outs.watchdog_expired_n;
    endproperty
    a_expired_supply: assert property (p_expired_supply)
        else $error("expired output low during supply low");
    property p_ce_force;
        @(posedge hclk) disable iff (!hresetn)
        ce_kill |=> outs.chip_enable_out_n;
    endproperty
    a_ce_force: assert property (p_ce_force)
        else $error("chip enable not forced high");
    property p_ce_pass;
        @(posedge hclk) disable iff (!hresetn)
        !ce_kill |=> outs.chip_enable_out_n == $past(ps.chip_enable_in_n);
    endproperty
    a_ce_pass: assert property (p_ce_pass)
        else $error("chip enable not passed through");
    property p_warn;
        @(posedge hclk) disable iff (!hresetn)
        ps.backup_active || ps.power_warn_sense_low |=> !outs.power_warn_n;
    endproperty
    a_warn: assert property (p_warn)
        else $error("power warning not low");
endmodule

// >>> ssw_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host processor side of the watchdog line
// ****************************************************************
module ssw_host_model #(
    parameter int GAP = 200
) (
    input  wire logic hclk,
    input  wire logic reset_n,
    input  wire logic service,
    input  wire logic kick,
    output logic      toggle
);
    int   gap_cnt;
    // Idle level at start, as after a processor reset
    logic tog_q = 1'b0;

    assign toggle = tog_q;

    // hold then service
    // Line left alone while reset is low; later kept well inside short timeout
    always @(posedge hclk)
    begin
        if (reset_n !== 1'b1 || !service)
            gap_cnt <= 0;
        else
            gap_cnt <= (gap_cnt == GAP - 1) ? 0 : gap_cnt + 1;
        if (kick || (service && reset_n === 1'b1 && gap_cnt == GAP - 1))
            tog_q <= ~tog_q;
    end
endmodule

// >>> tb_supply_supervisor_watchdog.sv
`timescale 1ns/1ps
module tb_supply_supervisor_watchdog;
    import ssw_pkg::*;
    // ****************************************************************
    // Clock, pins and instances
    // ****************************************************************
    localparam int DIV = 4;
    localparam int P   = 4;  // Ext timebase period, hclk cycles
    localparam int TOL = 16; // Sync and tick phase slack
    logic         hclk = 1'b0;
    logic         hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    logic [1:0]   htrans;
    logic [1:0]   ph = 2'b00;
    logic [2:0]   hsize, r;
    logic         sup, bak, pws, en, sel, tbi, cen, ext_on, kick, svc, tog;
    ssw_pins_type pins;
    ssw_outs_type outs;
    int           fail_count, total_checks, n;

    assign pins = {sup, bak, pws, tog, en, sel, tbi, cen};
    always #5 hclk = ~hclk;

    ssw_top #(.TB_DIV(DIV)) u_ssw_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .outs(outs));
    ssw_host_model #(.GAP(200)) u_ssw_host_model (
        .hclk(hclk), .reset_n(outs.reset_n), .service(svc), .kick(kick), .toggle(tog));

    // External timebase; stands still once internal mode is chosen
    always @(posedge hclk)
    begin
        ph <= ph + 2'd1;
        tbi <= ext_on ? ph[1] : 1'b0;
    end

    always @(posedge hclk)
        if (hresetn === 1'b1)
            check1(outs.reset, ~outs.reset_n, "reset mirror");

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task check1(input logic seen, input logic exp, input string msg);
        check({31'd0, seen}, {31'd0, exp}, msg);
    endtask

    // Cycle counts carry sync latency, so a window is accepted
    task near(input int seen, input int exp, input string msg);
        check1((seen >= exp - TOL) && (seen <= exp + TOL), 1'b1, msg);
    endtask

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
             output logic [31:0] q);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        hsel <= 1'b1;
        hsize <= 3'd2;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        q = hrdata;
    endtask

    task wait_rst(input logic v, output int c);
        c = 0;
        while (outs.reset_n !== v)
        begin
            @(posedge hclk);
            c++;
        end
    endtask

    task poke;
        kick <= 1'b1;
        @(posedge hclk);
        kick <= 1'b0;
    endtask

    function automatic logic exp_ce(input logic s, input logic b, input logic c);
        return (s | b) ? 1'b1 : c;
    endfunction

    function automatic logic exp_pw(input logic b, input logic w);
        return b ? 1'b0 : ~w;
    endfunction

    task give_verdict;
        $display("checks %0d fail_count %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, well past the planned run
    initial
    begin
        repeat (100000) @(posedge hclk);
        fail_count++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        {sup, bak, pws, sel, cen, kick, svc} = '0;
        en = 1'b1;
        ext_on = 1'b1;
        fail_count = 0;
        total_checks = 0;
        n = $urandom(32'he64f);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wait_rst(1'b1, n);
        near(n, 3 + 512 * P, "power-up pulse");
        ahb(1'b0, 32'h4, 32'h0, rd);
        check(rd & 32'h3f, 32'h33, "status run post");
        ahb(1'b1, 32'hc, 32'hffff_ffff, rd);
        ahb(1'b0, 32'hc, 32'h0, rd);
        check(rd, 32'h0, "unmapped");
        // Static line: long timeout, pulse, then repeats
        wait_rst(1'b0, n);
        near(n, 4096 * P, "post timeout");
        check1(outs.watchdog_expired_n, 1'b0, "expired low");
        wait_rst(1'b1, n);
        near(n, 512 * P, "pulse");
        wait_rst(1'b0, n);
        near(n, 4096 * P, "repeat timeout");
        wait_rst(1'b1, n);
        check1(outs.watchdog_expired_n, 1'b0, "expired held");
        poke();
        repeat (6) @(posedge hclk);
        check1(outs.watchdog_expired_n, 1'b1, "expired cleared");
        wait_rst(1'b0, n);
        near(n, 1024 * P - 7, "normal timeout");
        // Supply low in mid pulse, with long option set
        ahb(1'b1, 32'h0, 32'h1, rd);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd & 32'h3, 32'h1, "ctrl readback");
        check1(hresp, 1'b0, "bus okay");
        sup <= 1'b1;
        repeat (5) @(posedge hclk);
        check1(outs.watchdog_expired_n, 1'b1, "supply forces expired");
        check1(outs.supply_low_n, 1'b0, "supply low out");
        check1(outs.chip_enable_out_n, 1'b1, "ce blocked");
        check1(outs.reset_n, 1'b0, "reset in supply low");
        sup <= 1'b0;
        repeat (5) @(posedge hclk);
        check1(outs.supply_low_n, 1'b1, "supply back");
        check1(outs.reset_n, 1'b0, "reset held");
        wait_rst(1'b1, n);
        near(n, 2048 * P - 5, "long pulse");
        ahb(1'b1, 32'h0, 32'h0, rd);
        // Watchdog off: static line beyond timeout
        poke();
        // Edge must land first so the short limit is live when disabled
        repeat (6) @(posedge hclk);
        en <= 1'b0;
        repeat (6000) @(posedge hclk);
        check1(outs.reset_n, 1'b1, "disabled no reset");
        check1(outs.watchdog_expired_n, 1'b1, "disabled no expiry");
        en <= 1'b1;
        svc <= 1'b1;
        // Random pin levels while serviced
        repeat (24)
        begin
            r = 3'($urandom);
            cen <= r[0];
            pws <= r[1];
            bak <= r[2];
            repeat (5) @(posedge hclk);
            check1(outs.chip_enable_out_n, exp_ce(1'b0, r[2], r[0]), "ce");
            check1(outs.power_warn_n, exp_pw(r[2], r[1]), "warn");
            check1(outs.watchdog_expired_n, 1'b1, "expired in backup");
        end
        bak <= 1'b0;
        // Internal oscillator, short normal timeout
        ext_on <= 1'b0;
        sel <= 1'b1;
        svc <= 1'b0;
        repeat (8) @(posedge hclk);
        poke();
        wait_rst(1'b0, n);
        near(n, 655 * DIV, "internal short");
        wait_rst(1'b1, n);
        near(n, 327 * DIV, "internal pulse");
        repeat (3000) @(posedge hclk);
        check1(outs.reset_n, 1'b1, "long after reset");
        poke();
        wait_rst(1'b0, n);
        near(n, 655 * DIV, "short after toggle");
        // Reduced pins: 50ms pulse from long_reset clear, long limit even with short select
        ahb(1'b1, 32'h0, 32'h2, rd);
        wait_rst(1'b1, n);
        near(n, 327 * DIV - 2, "reduced pulse");
        poke();
        repeat (3000) @(posedge hclk);
        check1(outs.reset_n, 1'b1, "reduced fixed long");
        give_verdict();
    end
endmodule
